// file: rtl/psr_host.v
`timescale 1ns/100ps
`default_nettype none
`include "psr_defines.vh"
module psr_host (
	// clock and reset
	input  wire                 ref_clk_i,
	input  wire                 reset_i,
	// user request
	input  wire                 req_i,
	input  wire                 req_write_i,
	input  wire [`PSR_AW-1:0]   req_addr_i,
	input  wire [`PSR_DW-1:0]   req_wdata_i,
	input  wire [1:0]           req_be_i,
	input  wire                 sleep_i,
	output reg                  ready_o,
	output reg                  rd_valid_o,
	output reg  [`PSR_DW-1:0]   rd_data_o,
	output reg                  awake_o,
	// memory pins
	output reg  [`PSR_AW-1:0]   word_addr_o,
	output reg                  chip_select_low_o,
	output reg                  power_keep_select_o,
	output reg                  out_enable_n_o,
	output reg                  write_strobe_n_o,
	output reg                  low_byte_sel_n_o,
	output reg                  high_byte_sel_n_o,
	input  wire [`PSR_DW-1:0]   data_bus_i,
	output reg  [`PSR_DW-1:0]   data_bus_o,
	output reg                  data_bus_oe_n_o
);
	// one-hot sequencer states; a pin phase lives in exactly one of them
	localparam [5:0] ST_IDLE  = 6'h01;
	localparam [5:0] ST_RD    = 6'h02;
	localparam [5:0] ST_WR    = 6'h04;
	localparam [5:0] ST_WHIGH = 6'h08;
	localparam [5:0] ST_DPD   = 6'h10;
	localparam [5:0] ST_WAKE  = 6'h20;

	// current phase of the access sequencer
	reg  [5:0]         state;

	// two-flop synchroniser for the shared data pins
	reg  [`PSR_DW-1:0] rd_meta;
	reg  [`PSR_DW-1:0] rd_sync;

	// one phase timer serves every wait, loaded for one clock at a phase start
	reg                load;
	reg  [`PSR_CW-1:0] load_val;
	wire               done;

	// sized cycle count from a figure in the header
	// the timer starts one clock after its load, hence the minus one
	function [`PSR_CW-1:0] cyc;
		input integer n;
		begin
			cyc = n[`PSR_CW-1:0] - 16'h0001;
		end
	endfunction

	// done still reads high in the clock after a load, as the count is stale,
	// so every phase also waits for load to drop before trusting done
	psr_delay_cnt u_cnt (
		.ref_clk_i (ref_clk_i),
		.reset_i   (reset_i),
		.load_i    (load),
		.value_i   (load_val),
		.done_o    (done)
	);

	// the data pins are asynchronous to us, so two flops before use
	// no reset: the flops only ever feed captured read data
	always @(posedge ref_clk_i) begin
		rd_meta <= data_bus_i;
		rd_sync <= rd_meta;
	end

	// access sequencer; strobes end only on counter expiry so no pulse is short
	// hazard: write data is driven from the strobe's falling edge, so turnaround
	// after a read rests on the memory's float time and the idle clock between
	always @(posedge ref_clk_i) begin
		// one-clock pulses fall back to zero unless a branch below raises them
		load       <= 1'b0;
		load_val   <= 16'h0000;
		rd_valid_o <= 1'b0;
		// reset parks every pin in standby: chip deselected, strobes and lanes high
		// the memory keeps its contents, since power-keep stays high
		if (reset_i) begin
			state               <= ST_IDLE;
			ready_o             <= 1'b1;
			rd_data_o           <= 16'h0000;
			awake_o             <= 1'b1;
			word_addr_o         <= 20'h00000;
			chip_select_low_o   <= 1'b1;
			power_keep_select_o <= 1'b1;
			out_enable_n_o      <= 1'b1;
			write_strobe_n_o    <= 1'b1;
			low_byte_sel_n_o    <= 1'b1;
			high_byte_sel_n_o   <= 1'b1;
			data_bus_o          <= 16'h0000;
			data_bus_oe_n_o     <= 1'b1;
		end else begin
			case (state)
			// idle: standby between accesses, waiting for work or a sleep request
			ST_IDLE: begin
				// sleep wins over a new request; an access already under way still runs to its end before power-down
				if (sleep_i) begin
					power_keep_select_o <= 1'b0;
					chip_select_low_o   <= 1'b1;
					ready_o             <= 1'b0;
					awake_o             <= 1'b0;
					state               <= ST_DPD;
				end else if (req_i && ready_o) begin
					// address and lane selects are latched here and stand all access long
					ready_o           <= 1'b0;
					word_addr_o       <= req_addr_i;
					chip_select_low_o <= 1'b0;
					low_byte_sel_n_o  <= ~req_be_i[0];
					high_byte_sel_n_o <= ~req_be_i[1];
					load              <= 1'b1;
					if (req_write_i) begin
						// whole pulse covers setup-to-end, data setup and cycle
						write_strobe_n_o <= 1'b0;
						data_bus_o       <= req_wdata_i;
						data_bus_oe_n_o  <= 1'b0;
						load_val         <= cyc(`PSR_WR_CYC);
						state            <= ST_WR;
					end else begin
						// extra 2 cycles cover the input synchroniser
						out_enable_n_o <= 1'b0;
						load_val       <= cyc(`PSR_RD_CYC + 2);
						state          <= ST_RD;
					end
				end
			end

			// read: hold the pins until the timer covers access time and synchroniser
			ST_RD: begin
				if (done && !load) begin
					// the synchroniser holds bus data sampled two clocks before this edge
					rd_data_o         <= rd_sync;
					rd_valid_o        <= 1'b1;
					out_enable_n_o    <= 1'b1;
					chip_select_low_o <= 1'b1; // standby between accesses, no wait
					low_byte_sel_n_o  <= 1'b1;
					high_byte_sel_n_o <= 1'b1;
					ready_o           <= 1'b1;
					state             <= ST_IDLE;
				end
			end

			// write: strobe low; its rising edge ends the write and commits the data
			ST_WR: begin
				if (done && !load) begin
					// strobe, select and bus drive leave together; data need not be held
					write_strobe_n_o  <= 1'b1;
					chip_select_low_o <= 1'b1;
					data_bus_oe_n_o   <= 1'b1;
					load              <= 1'b1;
					load_val          <= cyc(`PSR_WE_HIGH);
					state             <= ST_WHIGH;
				end
			end

			// recovery: strobe high with the lanes still set before going idle
			ST_WHIGH: begin
				if (done && !load) begin
					// lanes release only now so they stay valid past the write end
					low_byte_sel_n_o  <= 1'b1;
					high_byte_sel_n_o <= 1'b1;
					ready_o           <= 1'b1;
					state             <= ST_IDLE;
				end
			end

			// deep power-down: contents are lost, only a dropped sleep request leaves
			ST_DPD: begin
				if (!sleep_i) begin
					// the timer holds off new requests for the full power-down wait
					power_keep_select_o <= 1'b1;
					load                <= 1'b1;
					load_val            <= cyc(`PSR_DPD_WAIT);
					state               <= ST_WAKE;
				end
			end

			// wake: power-keep is back high, no access until the full wait has run
			ST_WAKE: begin
				if (done && !load) begin
					// awake and ready rise together, so no request slips in early
					awake_o <= 1'b1;
					ready_o <= 1'b1;
					state   <= ST_IDLE;
				end
			end

			// an illegal state code falls back to idle rather than locking up
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // psr_host
`default_nettype wire

// file: common/psr_defines.vh
`ifndef PSR_DEFINES_VH
`define PSR_DEFINES_VH
// timing figures in ns, cycle counts derived at 8 ns per clock
`define PSR_CLK_NS        8
`define PSR_RD_CYC_NS     70
`define PSR_WR_CYC_NS     70
`define PSR_WR_PULSE_NS   50
`define PSR_SETUP_END_NS  60
`define PSR_DATA_SETUP_NS 35
`define PSR_WE_HIGH_NS    5
`define PSR_RD_ACC_NS     70
`define PSR_DPD_WAIT_NS   200000
// least times round up
`define PSR_CEIL(ns) (((ns) + `PSR_CLK_NS - 1) / `PSR_CLK_NS)
`define PSR_RD_CYC     `PSR_CEIL(`PSR_RD_CYC_NS)
`define PSR_WR_CYC     `PSR_CEIL(`PSR_WR_CYC_NS)
`define PSR_WR_PULSE   `PSR_CEIL(`PSR_WR_PULSE_NS)
`define PSR_SETUP_END  `PSR_CEIL(`PSR_SETUP_END_NS)
`define PSR_DATA_SETUP `PSR_CEIL(`PSR_DATA_SETUP_NS)
`define PSR_WE_HIGH    `PSR_CEIL(`PSR_WE_HIGH_NS)
`define PSR_RD_ACC     `PSR_CEIL(`PSR_RD_ACC_NS)
`define PSR_DPD_WAIT   `PSR_CEIL(`PSR_DPD_WAIT_NS)
// widths
`define PSR_AW 20
`define PSR_DW 16
`define PSR_CW 16
`endif

// file: rtl/psr_delay_cnt.v
`timescale 1ns/100ps
`default_nettype none
`include "psr_defines.vh"
// loadable down counter; done is high while the count is zero
module psr_delay_cnt (
	// clock and reset
	input  wire                  ref_clk_i,
	input  wire                  reset_i,
	// load
	input  wire                  load_i,
	input  wire [`PSR_CW-1:0]    value_i,
	// status
	output wire                  done_o
);
	reg [`PSR_CW-1:0] count;

	// a load wins over counting so back to back phases lose no cycle
	always @(posedge ref_clk_i) begin
		if (reset_i) begin
			count <= 16'h0000;
		end else if (load_i) begin
			count <= value_i;
		end else if (count != 16'h0000) begin
			count <= count - 16'h0001;
		end
	end

	assign done_o = (count == 16'h0000);
endmodule // psr_delay_cnt
`default_nettype wire

// file: sim/psr_mem.sv
`timescale 1ns/100ps
`default_nettype none
// far-side memory; read data shows up DLY ns after the controls settle
module psr_mem #(parameter int DLY = 64) (
	input  wire logic [19:0] a,
	input  wire logic        cs_n, pk, oe_n, we_n, lb_n, ub_n,
	input  wire logic [15:0] d,
	output wire logic [15:0] q
);
	logic [15:0] m [int];
	logic [15:0] qi, rv, nv, wd, dd;
	logic [19:0] wa;
	logic [1:0]  wl;
	logic        act = 0;
	assign #1 dd = d; // data need not outlast the write end
	assign #(DLY) q = qi; // slow but inside the access limit
	// read lanes; an undriven lane shows the inverse of the stored word
	always @(a, cs_n, pk, oe_n, we_n, lb_n, ub_n, act) begin
		rv = m.exists(a) ? m[a] : 16'hxxxx;
		qi = ~rv;
		if (pk && !cs_n && !oe_n && we_n) begin
			if (!lb_n) qi[7:0] = rv[7:0];
			if (!ub_n) qi[15:8] = rv[15:8];
		end
	end
	// track the write; only lanes with a low byte select are taken
	always @(a, dd, cs_n, we_n, pk, lb_n, ub_n)
		if (pk && !cs_n && !we_n) {wa, wd, wl, act} = {a, dd, !ub_n, !lb_n, 1'b1};
	// commit at the write end, so end-of-write bus turnaround is harmless
	always @(posedge we_n or posedge cs_n)
		if (act) begin
			nv = m.exists(wa) ? m[wa] : 16'h0000;
			if (wl[0]) nv[7:0] = wd[7:0];
			if (wl[1]) nv[15:8] = wd[15:8];
			m[wa] = nv;
			act = 0;
		end
	// deep power-down loses the contents, standby keeps them
	always @(negedge pk) m.delete();
endmodule // psr_mem
`default_nettype wire

// file: sim/psr_host_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "psr_defines.vh"
// pin timing watcher for the host
module psr_host_asserts (
	input wire logic ref_clk_i, reset_i, req_i, req_write_i, sleep_i, ready_o, rd_valid_o,
	input wire logic awake_o, chip_select_low_o, power_keep_select_o, out_enable_n_o,
	input wire logic write_strobe_n_o, low_byte_sel_n_o, high_byte_sel_n_o, data_bus_oe_n_o,
	input wire logic [1:0]          req_be_i,
	input wire logic [`PSR_AW-1:0] word_addr_o,
	input wire logic [`PSR_DW-1:0] data_bus_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	int cs_cnt = 0, ws_cnt = 0, pk_cnt = 0;
	// whole clocks of select, strobe and wake wait
	always @(posedge ref_clk_i) begin
		cs_cnt <= (chip_select_low_o || (low_byte_sel_n_o && high_byte_sel_n_o)) ? 0 : cs_cnt + 1;
		ws_cnt <= write_strobe_n_o ? 0 : ws_cnt + 1;
		pk_cnt <= (!power_keep_select_o || awake_o) ? 0 : pk_cnt + 1;
	end
	sequence s_take(bit wr);
		req_i && ready_o && !sleep_i && req_write_i == wr;
	endsequence
	a_read_answer: assert property (s_take(1'b0) |-> ##13 rd_valid_o)
		else $error("read answer late");
	a_write_done: assert property (s_take(1'b1) ##0 req_be_i != 0 |-> ##13 ready_o)
		else $error("write end late");
	a_byte_lanes: assert property (req_i && ready_o && !sleep_i |=>
		low_byte_sel_n_o == !$past(req_be_i[0]) && high_byte_sel_n_o == !$past(req_be_i[1]))
		else $error("byte selects wrong");
	a_read_access: assert property ($rose(rd_valid_o) |->
		$past(!out_enable_n_o && !chip_select_low_o, 10)) else $error("access too short");
	a_cycle_len: assert property ($rose(chip_select_low_o) && cs_cnt != 0 |-> cs_cnt >= 9)
		else $error("cycle too short");
	a_strobe_len: assert property ($rose(write_strobe_n_o) |-> ws_cnt >= 7)
		else $error("write pulse too short");
	a_addr_held: assert property (!chip_select_low_o && $past(!chip_select_low_o) |->
		$stable(word_addr_o)) else $error("address moved");
	a_wdata_held: assert property (!write_strobe_n_o |=> write_strobe_n_o ||
		($stable(data_bus_o) && !data_bus_oe_n_o)) else $error("write data moved");
	a_no_clash: assert property (!out_enable_n_o |-> data_bus_oe_n_o)
		else $error("bus contention");
	a_sleep_entry: assert property (sleep_i && ready_o && awake_o |->
		##[1:2] !power_keep_select_o) else $error("no power-down");
	a_wake_wait: assert property ($rose(awake_o) |-> pk_cnt >= `PSR_DPD_WAIT - 1)
		else $error("wake too early");
endmodule // psr_host_asserts
bind psr_host psr_host_asserts chk_u (.ref_clk_i, .reset_i, .req_i, .req_write_i, .sleep_i,
	.ready_o, .rd_valid_o, .awake_o, .chip_select_low_o, .power_keep_select_o, .out_enable_n_o,
	.write_strobe_n_o, .low_byte_sel_n_o, .high_byte_sel_n_o, .data_bus_oe_n_o, .req_be_i,
	.word_addr_o, .data_bus_o);
`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic ref_clk_i = 0, reset_i = 1, req_i = 0, req_write_i = 0, sleep_i = 0;
	logic [19:0] req_addr_i = 0;
	logic [15:0] req_wdata_i = 0;
	logic [1:0]  req_be_i = 0;
	wire logic ready_o, rd_valid_o, awake_o, cs_n, pk, oe_n, we_n, lb_n, ub_n, doe_n;
	wire logic [19:0] addr;
	wire logic [15:0] rd_data_o, dout, mq, bus;
	int error_cnt = 0, compares = 0, cyc = 0;
	logic [15:0] ref_m [int];
	always #4 ref_clk_i = ~ref_clk_i;
	assign bus = doe_n ? mq : dout; // host owns the bus only while enabled
	psr_host dut_u (.ref_clk_i, .reset_i, .req_i, .req_write_i, .req_addr_i, .req_wdata_i,
		.req_be_i, .sleep_i, .ready_o, .rd_valid_o, .rd_data_o, .awake_o, .word_addr_o(addr),
		.chip_select_low_o(cs_n), .power_keep_select_o(pk), .out_enable_n_o(oe_n),
		.write_strobe_n_o(we_n), .low_byte_sel_n_o(lb_n), .high_byte_sel_n_o(ub_n),
		.data_bus_i(bus), .data_bus_o(dout), .data_bus_oe_n_o(doe_n));
	psr_mem mem_u (.a(addr), .cs_n, .pk, .oe_n, .we_n, .lb_n, .ub_n, .d(bus), .q(mq));
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// one access, driven on falling edges; a read is checked against the reference, a write updates it
	task automatic acc(bit wr, logic [19:0] ad, logic [15:0] wd, logic [1:0] be);
		int k;
		logic [15:0] mk;
		mk = {{8{be[1]}}, {8{be[0]}}};
		while (ready_o !== 1'b1) @(negedge ref_clk_i);
		{req_i, req_write_i, req_addr_i, req_wdata_i, req_be_i} = {1'b1, wr, ad, wd, be};
		@(negedge ref_clk_i);
		req_i = 0;
		for (k = 0; k < 30 && rd_valid_o !== 1'b1 && !(wr && ready_o === 1'b1); k++)
			@(negedge ref_clk_i);
		if (wr) begin
			if (be != 0) chk(k, 12);
			ref_m[ad] = ((ref_m.exists(ad) ? ref_m[ad] : 16'h0000) & ~mk) | (wd & mk);
		end else begin
			chk(k, 12);
			chk(rd_data_o & mk, ref_m[ad] & mk);
		end
	endtask
	// main sequence: lanes and back-to-back traffic, then deep power-down
	initial begin
		int i, b;
		logic [19:0] ad;
		void'($urandom(32'h6275));
		repeat (20) @(negedge ref_clk_i);
		reset_i = 0;
		for (i = 0; i < 6; i++) begin
			ad = (i == 5) ? 20'hfffff : 20'($urandom);
			acc(1, ad, 16'($urandom), 2'b11);
			acc(1, ad, 16'($urandom), 2'(i % 3));
			for (b = 1; b < 4; b++) acc(0, ad, 16'h0000, 2'(b));
		end
		$display("test byte lanes done");
		sleep_i = 1;
		for (i = 0; i < 10 && pk !== 1'b0; i++) @(negedge ref_clk_i);
		chk(awake_o, 0);
		sleep_i = 0;
		for (i = 0; i < 26000 && awake_o !== 1'b1; i++) @(negedge ref_clk_i);
		chk(i >= 25000, 1);
		acc(1, ad, 16'h5a3c, 2'b11);
		acc(0, ad, 16'h0000, 2'b11);
		$display("test deep power-down done");
		complete_run;
	end
	// hang guard
	always @(posedge ref_clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			error_cnt++;
			complete_run;
		end
	end
endmodule // testbench
`default_nettype wire
